//--- drive_param_reply_framer.sv
// Reply string builder for parameter reads on the serial link
`timescale 1ns/100ps
`include "reply_framer_consts.svh"

module drive_param_reply_framer #(
  parameter int PARAM_W = 10
) (
  // Clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         clk_en,
  // Configuration from the station number and protocol select settings
  input  wire logic [6:0]                   station_number_setting,
  input  wire logic                         protocol_select,
  // Parsed read command
  input  wire logic                         req_valid,
  input  wire reply_framer_pkg::read_req_t  req,
  output logic                              req_ready_q,
  // Parameter store lookup
  output logic                              fetch_q,
  output logic [PARAM_W-1:0]                fetch_param_q,
  input  wire logic                         data_valid,
  input  wire reply_framer_pkg::param_data_t data,
  // Drive state and alarm feed
  input  wire reply_framer_pkg::run_t       run_state,
  input  wire logic                         alarm_valid,
  input  wire logic [3:0]                   alarm_code,
  // Character stream to the transmitter
  output logic                              tx_valid_q,
  output logic [6:0]                        tx_char_q,
  input  wire logic                         tx_ready,
  output logic                              busy_q
);
  reply_framer_pkg::frame_state_t state_q;
  logic [15:0] alarms;
  logic [6:0]  line_q [25];
  logic [4:0]  len_q;
  logic [4:0]  idx_q;
  logic        buf_ready;
  logic        buf_valid;
  logic [6:0]  buf_data;
  logic        push;
  logic        long_q;

  alarm_history u_hist (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .alarm_valid (alarm_valid),
    .alarm_code  (alarm_code),
    .history_q   (alarms)
  );

  // Digit n (0 = units) of a binary value as an ASCII character
  function automatic logic [6:0] dig(input logic [16:0] v, input logic [2:0] n);
    logic [16:0] t;
    t = v;
    for (int i = 0; i < 5; i++) begin
      if (3'(i) < n) begin
        t = t / 17'd10;
      end
    end
    return `RF_CHAR_ZERO + 7'(t % 17'd10);
  endfunction : dig

  function automatic logic [6:0] bcd(input logic [3:0] d);
    return `RF_CHAR_ZERO + {3'h0, d};
  endfunction : bcd

  function automatic logic [4:0] clamp_type(input logic [4:0] t);
    return (t > `RF_TYPE_MAX) ? `RF_TYPE_MAX : t;
  endfunction : clamp_type

  // Range trimming per type so out-of-range stored bits never leak out
  function automatic logic [15:0] trim(input logic [4:0] t, input logic [15:0] v);
    logic [15:0] lim;
    lim = 16'hffff;
    unique case (t)
      5'h03, 5'h04, 5'h05, 5'h0c, 5'h0d, 5'h0e: lim = 16'h00ff;
      5'h06, 5'h0f, 5'h14, 5'h15, 5'h16:        lim = 16'h0001;
      5'h10:                                    lim = 16'h000f;
      5'h11:                                    lim = 16'h0007;
      5'h12:                                    lim = 16'h0003;
      5'h13:                                    lim = 16'h03ff;
      default:                                  lim = 16'hffff;
    endcase
    return (v > lim) ? lim : v;
  endfunction : trim

  function automatic logic [3:0] status_digit(input reply_framer_pkg::run_t r);
    unique case (r)
      reply_framer_pkg::RUN_REV: return `RF_STAT_REV;
      reply_framer_pkg::RUN_FWD: return `RF_STAT_FWD;
      default:                   return `RF_STAT_STOP;
    endcase
  endfunction : status_digit

  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= reply_framer_pkg::ST_IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        reply_framer_pkg::ST_IDLE:
          if (req_valid && req.unit == station_number_setting) begin
            state_q <= reply_framer_pkg::ST_FETCH;
          end
        reply_framer_pkg::ST_FETCH:
          if (data_valid) begin
            state_q <= reply_framer_pkg::ST_BUILD;
          end
        reply_framer_pkg::ST_BUILD:
          state_q <= reply_framer_pkg::ST_SEND;
        reply_framer_pkg::ST_SEND:
          if (push && idx_q == len_q - 5'h1) begin
            state_q <= reply_framer_pkg::ST_IDLE;
          end
      endcase
    end
  end

  // Request acceptance, mismatched ids are consumed silently
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_ready_q   <= 1'b0;
      fetch_q       <= 1'b0;
      fetch_param_q <= '0;
      long_q        <= 1'b0;
    end else if (clk_en) begin
      req_ready_q <= (state_q == reply_framer_pkg::ST_IDLE) && req_valid && !req_ready_q;
      fetch_q     <= 1'b0;
      if (state_q == reply_framer_pkg::ST_IDLE && req_valid
          && req.unit == station_number_setting) begin
        fetch_q       <= 1'b1;
        fetch_param_q <= PARAM_W'(req.param);
        long_q        <= protocol_select;
      end
    end
  end

  // Line image: P,uu,nn(n),tt,ddddd,s,aaaa CR, all fields zero padded
  always_ff @(posedge clk) begin
    if (clk_en && state_q == reply_framer_pkg::ST_FETCH && data_valid) begin
      logic [4:0]  p;
      logic [4:0]  tc;
      logic [15:0] v;
      p  = 5'h0;
      tc = clamp_type(data.type_code);
      v  = trim(tc, data.value); // 16-bit value trimmed to the type's limit, host applies sign
      line_q[0] <= `RF_CHAR_HEAD_P;
      line_q[1] <= `RF_CHAR_COMMA;
      line_q[2] <= dig({10'h0, station_number_setting}, 3'h1);
      line_q[3] <= dig({10'h0, station_number_setting}, 3'h0);
      line_q[4] <= `RF_CHAR_COMMA;
      if (long_q) begin
        line_q[5] <= dig({7'h0, fetch_param_q}, 3'h2);
        p = 5'h1;
      end
      line_q[5+p] <= dig({7'h0, fetch_param_q}, 3'h1);
      line_q[6+p] <= dig({7'h0, fetch_param_q}, 3'h0);
      line_q[7+p] <= `RF_CHAR_COMMA;
      line_q[8+p] <= dig({12'h0, tc}, 3'h1);
      line_q[9+p] <= dig({12'h0, tc}, 3'h0);
      line_q[10+p] <= `RF_CHAR_COMMA;
      for (int i = 0; i < 5; i++) begin
        line_q[11+p+5'(i)] <= dig({1'b0, v}, 3'(4 - i));
      end
      line_q[16+p] <= `RF_CHAR_COMMA;
      line_q[17+p] <= bcd(status_digit(run_state));
      line_q[18+p] <= `RF_CHAR_COMMA;
      for (int i = 0; i < 4; i++) begin
        line_q[19+p+5'(i)] <= bcd(alarms[15-4*i -: 4]);
      end
      line_q[23+p] <= `RF_CHAR_CR;
      len_q <= long_q ? (`RF_LEN_LONG + 5'h1) : (`RF_LEN_SHORT + 5'h1);
    end
  end

  // Character index
  assign push = (state_q == reply_framer_pkg::ST_SEND) && buf_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_q <= 5'h0;
    end else if (clk_en) begin
      if (state_q != reply_framer_pkg::ST_SEND) begin
        idx_q <= 5'h0;
      end else if (push) begin
        idx_q <= idx_q + 5'h1;
      end
    end
  end

  char_buffer #(.WIDTH(7)) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_data   (line_q[idx_q]),
    .in_ready  (buf_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (!tx_valid_q || tx_ready)
  );

  // Output register; the UART adds parity and stop bits per baud code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_valid_q <= 1'b0;
      tx_char_q  <= 7'h00;
      busy_q     <= 1'b0;
    end else if (clk_en) begin
      busy_q <= (state_q != reply_framer_pkg::ST_IDLE) || buf_valid;
      if (!tx_valid_q || tx_ready) begin
        tx_valid_q <= buf_valid;
        tx_char_q  <= buf_data;
      end
    end
  end

  property p_no_spontaneous;
    @(posedge clk) disable iff (sys_rst)
      (state_q == reply_framer_pkg::ST_IDLE && !(req_valid && req.unit == station_number_setting))
        |=> state_q == reply_framer_pkg::ST_IDLE;
  endproperty
  a_no_spontaneous: assert property (p_no_spontaneous)
    else $error("reply started without a matching read");
  // The path is empty before a reply starts, so a rising valid always carries the head
  property p_head;
    @(posedge clk) disable iff (sys_rst)
      $rose(tx_valid_q) |-> tx_char_q == 7'h50;
  endproperty
  a_head: assert property (p_head) else $error("first character sent is not P");
  property p_first_char;
    @(posedge clk) disable iff (sys_rst)
      (state_q == reply_framer_pkg::ST_SEND && idx_q == 5'h0 && push) |-> line_q[0] == 7'h50;
  endproperty
  a_first_char: assert property (p_first_char) else $error("reply does not open with P");
  property p_unit;
    @(posedge clk) disable iff (sys_rst)
      (state_q == reply_framer_pkg::ST_SEND) |-> line_q[2] == dig({10'h0, station_number_setting}, 3'h1);
  endproperty
  a_unit: assert property (p_unit) else $error("unit id digit wrong");
  property p_len;
    @(posedge clk) disable iff (sys_rst)
      (state_q == reply_framer_pkg::ST_SEND) |-> len_q == (long_q ? 5'd25 : 5'd24);
  endproperty
  a_len: assert property (p_len) else $error("reply length wrong");
  property p_cr_last;
    @(posedge clk) disable iff (sys_rst)
      (push && idx_q == len_q - 5'h1) |-> line_q[idx_q] == 7'h0d;
  endproperty
  a_cr_last: assert property (p_cr_last) else $error("reply not ended by CR");
  property p_silent;
    @(posedge clk) disable iff (sys_rst)
      (state_q == reply_framer_pkg::ST_IDLE && req_valid && req.unit != station_number_setting)
        |=> !fetch_q;
  endproperty
  a_silent: assert property (p_silent) else $error("fetch for foreign unit");
  property p_fetch;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && state_q == reply_framer_pkg::ST_IDLE && req_valid
       && req.unit == station_number_setting) |=> fetch_q && state_q == reply_framer_pkg::ST_FETCH;
  endproperty
  a_fetch: assert property (p_fetch) else $error("read not answered");
  property p_ascii;
    @(posedge clk) disable iff (sys_rst)
      tx_valid_q |-> (tx_char_q == 7'h0d || tx_char_q == 7'h2c || tx_char_q == 7'h50
                      || (tx_char_q >= 7'h30 && tx_char_q <= 7'h39));
  endproperty
  a_ascii: assert property (p_ascii) else $error("non reply character sent");
  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_char_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled character lost");
  property p_status;
    @(posedge clk) disable iff (sys_rst)
      (state_q == reply_framer_pkg::ST_SEND)
        |-> line_q[17+long_q] inside {7'h31, 7'h32, 7'h33};
  endproperty
  a_status: assert property (p_status) else $error("status digit out of range");
  c_short: cover property (@(posedge clk) $fell(busy_q) && !long_q);
  c_long: cover property (@(posedge clk) $fell(busy_q) && long_q);
  c_stall: cover property (@(posedge clk) tx_valid_q && !tx_ready && buf_valid);
  c_foreign: cover property (@(posedge clk) req_ready_q && !fetch_q);
endmodule : drive_param_reply_framer

//--- reply_framer_consts.svh
// Constants for the parameter reply framer
`ifndef REPLY_FRAMER_CONSTS_SVH
`define REPLY_FRAMER_CONSTS_SVH
`define RF_CHAR_HEAD_P   7'h50
`define RF_CHAR_COMMA    7'h2c
`define RF_CHAR_CR       7'h0d
`define RF_CHAR_ZERO     7'h30
`define RF_STAT_REV      4'h1
`define RF_STAT_FWD      4'h2
`define RF_STAT_STOP     4'h3
`define RF_TYPE_MAX      5'h16
`define RF_ALARM_DIGITS  3'h4
`define RF_LEN_SHORT     5'h17
`define RF_LEN_LONG      5'h18
`endif

//--- reply_framer_pkg.sv
// Types shared by the parameter reply framer files
package reply_framer_pkg;
  typedef struct packed {
    logic [6:0]  unit;
    logic [9:0]  param;
  } read_req_t;
  typedef struct packed {
    logic [4:0]  type_code;
    logic [15:0] value;
  } param_data_t;
  typedef struct packed {
    logic [1:0]  dir;
    logic [15:0] alarms;
  } drive_state_t;
  typedef enum logic [1:0] {
    RUN_STOP = 2'b00,
    RUN_FWD  = 2'b01,
    RUN_REV  = 2'b10
  } run_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_BUILD = 2'b10,
    ST_SEND  = 2'b11
  } frame_state_t;
endpackage : reply_framer_pkg

//--- alarm_history.sv
// Four-deep alarm history, oldest entry in the top digit
`timescale 1ns/100ps
module alarm_history (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // New alarm
  input  wire logic        alarm_valid,
  input  wire logic [3:0]  alarm_code,
  // History, one BCD digit per entry
  output logic [15:0] history_q
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      history_q <= 16'h0000;
    end else if (clk_en && alarm_valid) begin
      history_q <= {history_q[11:0], alarm_code};
    end
  end
endmodule : alarm_history

//--- char_buffer.sv
// Two-entry skid buffer for outgoing characters
`timescale 1ns/100ps
module char_buffer #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_q [2];
  logic             rd_q;
  logic             wr_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign push      = in_valid && (cnt_q != 2'h2);
  assign pop       = out_ready && (cnt_q != 2'h0);
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : char_buffer

//--- host_reply_sink.sv
// Host side model that takes reply characters with random stalls
`timescale 1ns/100ps
module host_reply_sink (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Stall control
  input  wire logic       slow,
  // Character stream from the framer
  input  wire logic       tx_valid_q,
  input  wire logic [6:0] tx_char_q,
  output logic            tx_ready
);
  logic [15:0] stall_q;
  logic [6:0]  rx_q[$];
  int          frames;

  // Slow mode thins ready out so the framer's buffer backs up
  always_ff @(posedge clk) begin
    stall_q  <= sys_rst ? 16'hace1 :
                {stall_q[14:0], stall_q[15] ^ stall_q[13] ^ stall_q[12] ^ stall_q[10]};
    tx_ready <= !sys_rst && (slow ? (stall_q[0] & stall_q[3]) : (stall_q[0] | stall_q[3]));
  end

  // Parity and stop bits belong to the UART, so only bare characters arrive here
  always @(posedge clk) begin
    if (tx_valid_q && tx_ready) begin
      rx_q.push_back(tx_char_q);
      if (tx_char_q == 7'h0d) frames++;
    end
  end
endmodule : host_reply_sink

//--- tb_top.sv
// Self-checking bench for the parameter reply framer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  localparam logic [6:0] CM = 7'h2c;
  logic                          clk, sys_rst, clk_en, protocol_select, slow;
  logic                          req_valid, req_ready_q, fetch_q, data_valid, alarm_valid;
  logic                          tx_valid_q, tx_ready, busy_q;
  logic [6:0]                    station_number_setting, tx_char_q;
  logic [9:0]                    fetch_param_q;
  logic [3:0]                    alarm_code;
  logic [15:0]                   hist;
  logic [31:0]                   rnd_q;
  logic [6:0]                    exp_q[$];
  reply_framer_pkg::read_req_t   req;
  reply_framer_pkg::param_data_t data;
  reply_framer_pkg::run_t        run_state;
  int                            bad_count, num_checks, fetch_cnt, replies, i;

  drive_param_reply_framer dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .station_number_setting(station_number_setting), .protocol_select(protocol_select),
    .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q), .fetch_q(fetch_q),
    .fetch_param_q(fetch_param_q), .data_valid(data_valid), .data(data),
    .run_state(run_state), .alarm_valid(alarm_valid), .alarm_code(alarm_code),
    .tx_valid_q(tx_valid_q), .tx_char_q(tx_char_q), .tx_ready(tx_ready), .busy_q(busy_q));
  host_reply_sink host (.clk(clk), .sys_rst(sys_rst), .slow(slow), .tx_valid_q(tx_valid_q),
    .tx_char_q(tx_char_q), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (fetch_q === 1'b1) fetch_cnt++;

  function automatic int rnd(input int n);
    rnd_q = {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1] ^ rnd_q[0]};
    return int'(rnd_q[15:0]) % n;
  endfunction : rnd

  // Per-type upper bound; codes not listed run the full 16 bits
  function automatic int maxv(input int t);
    case (t)
      3, 4, 5, 12, 13, 14: return 255;
      6, 15, 20, 21, 22:   return 1;
      16:                  return 15;
      17:                  return 7;
      18:                  return 3;
      19:                  return 1023;
      default:             return 65535;
    endcase
  endfunction : maxv

  function automatic logic [6:0] dig(input int v);
    return 7'(7'h30 + v % 10);
  endfunction : dig

  task automatic span(input string nm, input int a, input int k);
    for (int j = a; j < a + k; j++) `CHK(nm, exp_q[j], host.rx_q[j])
  endtask : span

  task automatic push_alarm(input int c);
    @(posedge clk);
    alarm_valid <= 1'b1;
    alarm_code  <= 4'(c);
    hist = {hist[11:0], 4'(c)};
    @(posedge clk);
    alarm_valid <= 1'b0;
  endtask : push_alarm

  task automatic read_once(input int st, input int p, input int ty, input int v, input int rs,
                           input bit pw3, input bit hit);
    int n, te, ve, f0, w;
    te = ty > 22 ? 22 : ty;
    ve = v > maxv(te) ? maxv(te) : v;
    w  = 2 + pw3;
    f0 = fetch_cnt;
    host.rx_q.delete();
    @(posedge clk);
    station_number_setting <= 7'(st);
    protocol_select        <= pw3;
    run_state              <= rs == 0 ? reply_framer_pkg::RUN_STOP :
                              rs == 1 ? reply_framer_pkg::RUN_FWD : reply_framer_pkg::RUN_REV;
    req_valid              <= 1'b1;
    req                    <= '{unit: hit ? 7'(st) : 7'(st % 99 + 1), param: 10'(p)};
    for (n = 0; n < 20 && req_ready_q !== 1'b1; n++) @(posedge clk);
    req_valid <= 1'b0;
    if (hit) begin
      for (n = 0; n < 10 && fetch_q !== 1'b1; n++) @(posedge clk);
      `CHK("fetch_param", 10'(p), fetch_param_q)
      repeat (rnd(4)) @(posedge clk);
      data_valid <= 1'b1;
      data       <= '{type_code: 5'(ty), value: 16'(v)};
      @(posedge clk);
      data_valid <= 1'b0;
      for (n = 0; n < 800 && host.frames == replies; n++) @(posedge clk);
      for (n = 0; n < 50 && busy_q !== 1'b0; n++) @(posedge clk);
      `CHK("busy_done", 1'b0, busy_q)
      replies++;
    end else repeat (40) @(posedge clk);
    `CHK("reply_count", replies, host.frames)
    `CHK("fetch_count", f0 + hit, fetch_cnt)
    if (!hit) return;
    exp_q = {7'h50, CM, dig(st / 10), dig(st), CM};
    if (pw3) exp_q.push_back(dig(p / 100));
    exp_q = {exp_q, dig(p / 10), dig(p), CM, dig(te / 10), dig(te), CM, dig(ve / 10000),
             dig(ve / 1000), dig(ve / 100), dig(ve / 10), dig(ve), CM,
             dig(rs == 0 ? 3 : rs == 1 ? 2 : 1), CM, dig(hist[15:12]), dig(hist[11:8]),
             dig(hist[7:4]), dig(hist[3:0]), 7'h0d};
    `CHK("reply_len", exp_q.size(), host.rx_q.size())
    if (host.rx_q.size() != exp_q.size()) return;
    span("whole", 0, exp_q.size());
    span("unit", 2, 2);
    span("param", 5, w);
    span("type", 6 + w, 2);
    span("value", 9 + w, 5);
    span("status", 15 + w, 1);
    span("alarms", 17 + w, 4);
    span("end", 21 + w, 1);
  endtask : read_once

  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end

  initial begin
    rnd_q = 32'hc36d;
    hist  = 16'h0;
    {sys_rst, clk_en, protocol_select, slow, req_valid, data_valid, alarm_valid} = 7'h60;
    {station_number_setting, alarm_code, req, data} = '0;
    run_state = reply_framer_pkg::RUN_STOP;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK("busy_idle", 1'b0, busy_q)
    `CHK("tx_idle", 1'b0, tx_valid_q)
    // Unit ids stay within 01..99 as a host on a shared bus must
    for (i = 0; i < 24; i++) begin
      slow <= i[2];
      if (i % 4 == 3) push_alarm(rnd(10));
      read_once(rnd(99) + 1, i[0] ? rnd(1000) : rnd(100), i == 23 ? 31 : i,
                i % 3 == 0 ? 65535 : rnd(65536), i % 3, i[0], 1'b1);
    end
    read_once(rnd(99) + 1, 7, 2, 100, 0, 1'b0, 1'b0);
    repeat (5) push_alarm(rnd(10));
    read_once(99, 999, 19, 1024, 1, 1'b1, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b1;
    hist = 16'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    read_once(1, 0, 8, 32768, 2, 1'b0, 1'b1);
    wrap_up();
  end
endmodule : tb_top
